// File: hdl/dcc_top.sv
// Dual comparator control: polarity, pin routing, change detection and interrupt gating.
// Assumes raw comparator results arrive asynchronously and the register master never waits.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - Output high when noninverting exceeds inverting
// - Invert bit complements status and pin
// - Three-bit mode picks pin functions
// - Analog pins read as zero
// - Digital output pins override port value
// - Only mode 110 drives output pins
// - Status bits show adjusted state, zero in modes 000 and 111
// - Input switch selects inverting pin
// - One mode field governs both comparators
// - Only comparator two feeds counter gate
// - Control read captures reference latch
// - First-quarter sample compared with reference
// - Flag held while mismatch persists
// - Control write also refreshes reference
// - Flag cleared by zero, set by one
// - Request needs all three enables
// - Flag sets regardless of enables
// - Clear ignored during persistent mismatch
// - Modes 000 and 111 are off
// - Reset returns to mode 000
// - Gate output latched on counter falling edge
module dcc_top
	import dcc_pkg::*;
#(
	parameter int unsigned PORT_PINS = 6
) (
	input  wire logic                 CLK_SYS,      // System clock, 20 MHz.
	input  wire logic                 RST_B,        // Asynchronous active-low reset.
	input  wire logic [1:0]           ADDR,         // Register address.
	input  wire logic [7:0]           WDATA,        // Register write data.
	input  wire logic                 WR,           // Write strobe.
	input  wire logic                 RD,           // Read strobe.
	output logic      [7:0]           RDATA,        // Read data, one cycle after RD.
	input  wire logic [1:0]           CMP_RAW,      // Raw comparator results, bit0 is comparator one.
	input  wire logic                 CNT_CLK,      // Gated counter clock after prescaler.
	input  wire logic [PORT_PINS-1:0] PIN_IN,       // Pad levels of the port pins.
	input  wire logic [PORT_PINS-1:0] PORT_OUT,     // Port output latch values.
	input  wire logic [PORT_PINS-1:0] PORT_DIR,     // pin_direction_bit values, 1 means input.
	output logic      [PORT_PINS-1:0] PORT_RD,      // Port read values after analog masking.
	output logic      [PORT_PINS-1:0] PIN_OUT,      // Pad output data.
	output logic      [PORT_PINS-1:0] PIN_OE_B,     // Pad output enable, low drives.
	output logic      [PORT_PINS-1:0] PIN_ANALOG,   // Pin in analog function, input buffer off.
	output logic      [1:0]           INV_SEL,      // Inverting input select, 1 picks alternate pin.
	output logic      [1:0]           CMP_EN,       // Comparator core enables.
	output logic                      GATE_OUT,     // Comparator two level for counter gate.
	output logic                      IRQ           // Comparator interrupt request.
);
	initial begin
		if (PORT_PINS != 6) begin
			$error("dcc_top supports exactly six comparator pins");
		end
	end

	// Pin indices: 0 c1 inverting, 1 c1 noninverting, 2 c1 out, 3 c2 inverting, 4 c2 noninverting, 5 c2 out.
	localparam int P_C1N = 0;
	localparam int P_C1P = 1;
	localparam int P_C1O = 2;
	localparam int P_C2N = 3;
	localparam int P_C2P = 4;
	localparam int P_C2O = 5;

	logic       rst_s1_q;
	logic       rst_b_q;
	logic [1:0] cmp_s1_q;
	logic [1:0] cmp_s2_q;
	logic       cclk_s1_q;
	logic       cclk_s2_q;
	logic       cclk_old_q;
	logic [1:0] phase_q;
	logic [7:0] ctrl_q;
	logic [7:0] flags_q;
	logic [7:0] mask_q;
	logic [7:0] cfg_q;
	logic [7:0] rdata_q;
	logic       gate_q;
	logic       irq_q;
	logic [PORT_PINS-1:0] port_rd_q;
	logic [PORT_PINS-1:0] pin_out_q;
	logic [PORT_PINS-1:0] pin_oe_b_q;
	logic [PORT_PINS-1:0] pin_an_q;
	logic [PORT_PINS-1:0] pin_s1_q;
	logic [PORT_PINS-1:0] pin_s2_q;
	logic [1:0] inv_sel_q;
	logic [1:0] cmp_en_q;

	// Reset release through two flip-flops.
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rst_s1_q <= 1'b0;
			rst_b_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_b_q  <= rst_s1_q;
		end
	end

	// Two-stage synchronisers for comparator results, counter clock and pad levels.
	always_ff @(posedge CLK_SYS or negedge rst_b_q) begin
		if (!rst_b_q) begin
			cmp_s1_q   <= 2'h0;
			cmp_s2_q   <= 2'h0;
			cclk_s1_q  <= 1'b0;
			cclk_s2_q  <= 1'b0;
			cclk_old_q <= 1'b0;
			phase_q    <= 2'h0;
			pin_s1_q   <= '0;
			pin_s2_q   <= '0;
		end else begin
			pin_s1_q   <= PIN_IN;
			pin_s2_q   <= pin_s1_q;
			cmp_s1_q   <= CMP_RAW;
			cmp_s2_q   <= cmp_s1_q;
			cclk_s1_q  <= CNT_CLK;
			cclk_s2_q  <= cclk_s1_q;
			cclk_old_q <= cclk_s2_q;
			phase_q    <= phase_q + 2'h1;
		end
	end

	// Decoding of mode, polarity and register access.
	dcc_mode_t  mode;
	logic       cmp_on;
	logic [1:0] level;
	logic       q1;
	logic       ctrl_touch;
	logic       wr_ctrl;
	logic       wr_flags;
	logic       wr_mask;
	logic       wr_cfg;
	assign mode       = dcc_mode_t'(ctrl_q[DCC_CTRL_MODE +: 3]);
	assign cmp_on     = (mode != DCC_MODE_OFF_ANALOG) && (mode != DCC_MODE_OFF_DIGITAL);
	assign level[0]   = cmp_on & (cmp_s2_q[0] ^ ctrl_q[DCC_CTRL_INV1]);
	assign level[1]   = cmp_on & (cmp_s2_q[1] ^ ctrl_q[DCC_CTRL_INV2]);
	assign q1         = (phase_q == DCC_Q1_PHASE);
	assign ctrl_touch = (RD | WR) && (ADDR == DCC_ADDR_CTRL);
	assign wr_ctrl    = WR && (ADDR == DCC_ADDR_CTRL);
	assign wr_flags   = WR && (ADDR == DCC_ADDR_FLAGS);
	assign wr_mask    = WR && (ADDR == DCC_ADDR_MASK);
	assign wr_cfg     = WR && (ADDR == DCC_ADDR_CFG1);

	// Change detectors, one per comparator.
	logic [1:0] mism;
	logic [1:0] rise;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_mm
			dcc_mismatch u_mm (
				.clk        (CLK_SYS),
				.rst_b      (rst_b_q),
				.q1         (q1),
				.ctrl_touch (ctrl_touch),
				.level      (level[gi]),
				.mismatch   (mism[gi]),
				.rise       (rise[gi])
			);
		end
	endgenerate

	// Pin function per mode, returned as two bits per pin.
	function automatic logic [11:0] pin_func(input dcc_mode_t m);
		logic [11:0] f;
		f = {6{DCC_PIN_ANALOG}};
		case (m)
			DCC_MODE_OFF_ANALOG:  f = {6{DCC_PIN_ANALOG}};
			DCC_MODE_MUX3:        f = {DCC_PIN_IO, DCC_PIN_ANALOG, DCC_PIN_ANALOG, DCC_PIN_IO,
			                           DCC_PIN_ANALOG, DCC_PIN_ANALOG};
			DCC_MODE_COMMON:      f = {DCC_PIN_IO, DCC_PIN_ANALOG, DCC_PIN_IO, DCC_PIN_IO,
			                           DCC_PIN_ANALOG, DCC_PIN_ANALOG};
			DCC_MODE_INDEP1:      f = {DCC_PIN_IO, DCC_PIN_ANALOG, DCC_PIN_ANALOG, DCC_PIN_IO,
			                           DCC_PIN_IO, DCC_PIN_IO};
			DCC_MODE_COMMON_OUT:  f = {DCC_PIN_DIG, DCC_PIN_ANALOG, DCC_PIN_IO, DCC_PIN_DIG,
			                           DCC_PIN_ANALOG, DCC_PIN_ANALOG};
			DCC_MODE_OFF_DIGITAL: f = {6{DCC_PIN_IO}};
			default:              f = {DCC_PIN_IO, DCC_PIN_ANALOG, DCC_PIN_ANALOG, DCC_PIN_IO,
			                           DCC_PIN_ANALOG, DCC_PIN_ANALOG};
		endcase
		return f;
	endfunction

	// Next pin state from the pin function table.
	logic [11:0]          pf;
	logic [PORT_PINS-1:0] is_an;
	logic [PORT_PINS-1:0] is_dig;
	logic [PORT_PINS-1:0] dig_val;
	logic [PORT_PINS-1:0] pin_out_d;
	logic [PORT_PINS-1:0] pin_oe_b_d;
	logic [PORT_PINS-1:0] port_rd_d;
	assign pf = pin_func(mode);
	generate
		for (gi = 0; gi < PORT_PINS; gi++) begin : g_pin
			assign is_an[gi]      = (pf[2*gi +: 2] == DCC_PIN_ANALOG);
			assign is_dig[gi]     = (pf[2*gi +: 2] == DCC_PIN_DIG);
			assign dig_val[gi]    = (gi == P_C2O) ? level[1] : level[0];
			assign pin_out_d[gi]  = is_dig[gi] ? dig_val[gi] : PORT_OUT[gi];
			assign pin_oe_b_d[gi] = PORT_DIR[gi];
			assign port_rd_d[gi]  = is_an[gi] ? 1'b0 : pin_s2_q[gi];
		end
	endgenerate

	// Input switch applies to comparator one in 001, both in 010.
	logic [1:0] inv_sel_d;
	assign inv_sel_d[0] = ctrl_q[DCC_CTRL_CIS] && ((mode == DCC_MODE_MUX3) || (mode == DCC_MODE_MUX4));
	assign inv_sel_d[1] = ctrl_q[DCC_CTRL_CIS] && (mode == DCC_MODE_MUX4);

	// Flag next value: hardware set wins, clear ignored while mismatch persists.
	logic [7:0] flags_d;
	logic [7:0] flags_w;
	logic [7:0] hw_set;
	logic [7:0] hold;
	assign flags_w = wr_flags ? WDATA : flags_q;
	assign hw_set  = {3'h0, rise[1], rise[0], 3'h0} << (DCC_BIT_C1 - 3);
	assign hold    = {3'h0, mism[1], mism[0], 3'h0} << (DCC_BIT_C1 - 3);
	assign flags_d = flags_w | hw_set | hold;

	// Interrupt request needs individual, peripheral and global enables.
	logic irq_d;
	assign irq_d = cfg_q[DCC_CFG_GIE] && cfg_q[DCC_CFG_PERIPHERAL_IRQ_ENABLE] &&
	               |(flags_d & mask_q & ((8'h1 << DCC_BIT_C1) | (8'h1 << DCC_BIT_C2)));

	// Gate output: synchronised mode latches on the counter clock falling edge.
	logic gate_d;
	assign gate_d = !cfg_q[DCC_CFG_SYNC] ? level[1] :
	                (cclk_old_q && !cclk_s2_q) ? level[1] : gate_q;

	// Read data selection.
	logic [7:0] ctrl_view;
	logic [7:0] rdata_d;
	assign ctrl_view = {level[1], level[0], ctrl_q[5:0]};
	assign rdata_d = !RD ? 8'h00 :
	                 (ADDR == DCC_ADDR_CTRL)  ? ctrl_view :
	                 (ADDR == DCC_ADDR_FLAGS) ? flags_q :
	                 (ADDR == DCC_ADDR_MASK)  ? mask_q : cfg_q;

	// Registers and output flops.
	always_ff @(posedge CLK_SYS or negedge rst_b_q) begin
		if (!rst_b_q) begin
			ctrl_q     <= DCC_RESET_BYTE;
			flags_q    <= DCC_RESET_BYTE;
			mask_q     <= DCC_RESET_BYTE;
			cfg_q      <= DCC_RESET_BYTE;
			rdata_q    <= DCC_RESET_BYTE;
			gate_q     <= 1'b0;
			irq_q      <= 1'b0;
			port_rd_q  <= '0;
			pin_out_q  <= '0;
			pin_oe_b_q <= '1;
			pin_an_q   <= '1;
			inv_sel_q  <= 2'h0;
			cmp_en_q   <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= WDATA & DCC_CTRL_WMASK;
			end
			if (wr_mask) begin
				mask_q <= WDATA;
			end
			if (wr_cfg) begin
				cfg_q <= WDATA;
			end
			flags_q    <= flags_d;
			rdata_q    <= rdata_d;
			gate_q     <= gate_d;
			irq_q      <= irq_d;
			port_rd_q  <= port_rd_d;
			pin_out_q  <= pin_out_d;
			pin_oe_b_q <= pin_oe_b_d;
			pin_an_q   <= is_an;
			inv_sel_q  <= inv_sel_d;
			cmp_en_q   <= {2{cmp_on}};
		end
	end

	assign RDATA      = rdata_q;
	assign PORT_RD    = port_rd_q;
	assign PIN_OUT    = pin_out_q;
	assign PIN_OE_B   = pin_oe_b_q;
	assign PIN_ANALOG = pin_an_q;
	assign INV_SEL    = inv_sel_q;
	assign CMP_EN     = cmp_en_q;
	assign GATE_OUT   = gate_q;
	assign IRQ        = irq_q;

	// A new mismatch shows in the flag one edge later.
	property p_flag_set;
		@(posedge CLK_SYS) disable iff (!rst_b_q) rise[0] |=> flags_q[DCC_BIT_C1];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("change flag not set after mismatch");

	// A clear is refused while mismatch persists.
	property p_hold;
		@(posedge CLK_SYS) disable iff (!rst_b_q) mism[1] |=> flags_q[DCC_BIT_C2];
	endproperty
	a_hold: assert property (p_hold) else $error("change flag dropped during mismatch");

	// A control access loads the reference latch with the adjusted level.
	property p_touch;
		@(posedge CLK_SYS) disable iff (!rst_b_q) ctrl_touch |=> g_mm[0].u_mm.ref_q == $past(level[0]);
	endproperty
	a_touch: assert property (p_touch) else $error("mismatch survives control access");

	// Interrupt requires the global and peripheral enables.
	property p_irq;
		@(posedge CLK_SYS) disable iff (!rst_b_q) IRQ |-> $past(cfg_q[DCC_CFG_GIE]) && $past(cfg_q[DCC_CFG_PERIPHERAL_IRQ_ENABLE]);
	endproperty
	a_irq: assert property (p_irq) else $error("request without enables");

	// Off modes read back zero status bits on the register port.
	property p_off;
		@(posedge CLK_SYS) disable iff (!rst_b_q) (RD && (ADDR == DCC_ADDR_CTRL) && !cmp_on) |=> RDATA[7:6] == 2'h0;
	endproperty
	a_off: assert property (p_off) else $error("status nonzero while off");

	// A software clear takes effect when no mismatch holds the flag.
	property p_clear;
		@(posedge CLK_SYS) disable iff (!rst_b_q) (wr_flags && !WDATA[DCC_BIT_C1] && !mism[0]) |=> !flags_q[DCC_BIT_C1];
	endproperty
	a_clear: assert property (p_clear) else $error("change flag clear ignored without mismatch");

	// A written one sets the flag as a simulated event.
	property p_soft_set;
		@(posedge CLK_SYS) disable iff (!rst_b_q) (wr_flags && WDATA[DCC_BIT_C1]) |=> flags_q[DCC_BIT_C1];
	endproperty
	a_soft_set: assert property (p_soft_set) else $error("written one did not set change flag");

	// Analog pins read zero.
	property p_analog;
		@(posedge CLK_SYS) disable iff (!rst_b_q) is_an[P_C1N] |=> !PORT_RD[P_C1N];
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin read nonzero");

	// Output pins follow comparator only in mode 110.
	property p_dig;
		@(posedge CLK_SYS) disable iff (!rst_b_q) (mode == DCC_MODE_COMMON_OUT) |=> PIN_OUT[P_C2O] == $past(level[1]);
	endproperty
	a_dig: assert property (p_dig) else $error("output pin not driven by comparator");

	// Switch idle outside mux modes.
	property p_sw;
		@(posedge CLK_SYS) disable iff (!rst_b_q) (mode != DCC_MODE_MUX4) |=> !INV_SEL[1];
	endproperty
	a_sw: assert property (p_sw) else $error("comparator two switched outside mode 010");
endmodule

// File: hdl/dcc_pkg.sv
// Package for the dual comparator control block: register offsets, fields, modes and reset values.
// Assumes a simple byte-wide register port with one-cycle read latency.
package dcc_pkg;
	// Register offsets on the plain register port.
	localparam logic [1:0] DCC_ADDR_CTRL  = 2'h0; // comparator_control_reg
	localparam logic [1:0] DCC_ADDR_FLAGS = 2'h1; // peripheral_event_flags
	localparam logic [1:0] DCC_ADDR_MASK  = 2'h2; // peripheral_enable_mask
	localparam logic [1:0] DCC_ADDR_CFG1  = 2'h3; // irq enables and gate sync

	// Control register fields.
	localparam int DCC_CTRL_OUT2 = 7;
	localparam int DCC_CTRL_OUT1 = 6;
	localparam int DCC_CTRL_INV2 = 5;
	localparam int DCC_CTRL_INV1 = 4;
	localparam int DCC_CTRL_CIS  = 3;
	localparam int DCC_CTRL_MODE = 0;

	// Flag and mask register positions for the two comparators.
	localparam int DCC_BIT_C2 = 4;
	localparam int DCC_BIT_C1 = 3;

	// Own configuration register fields.
	localparam int DCC_CFG_GIE  = 7;
	localparam int DCC_CFG_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int DCC_CFG_SYNC = 0;

	localparam logic [7:0] DCC_RESET_BYTE = 8'h00;
	localparam logic [7:0] DCC_CTRL_WMASK = 8'h3f;

	// Operating modes of the shared mode field.
	typedef enum logic [2:0] {
		DCC_MODE_OFF_ANALOG = 3'b000,
		DCC_MODE_MUX3       = 3'b001,
		DCC_MODE_MUX4       = 3'b010,
		DCC_MODE_COMMON     = 3'b011,
		DCC_MODE_INDEP2     = 3'b100,
		DCC_MODE_INDEP1     = 3'b101,
		DCC_MODE_COMMON_OUT = 3'b110,
		DCC_MODE_OFF_DIGITAL= 3'b111
	} dcc_mode_t;

	// Pin function codes.
	localparam logic [1:0] DCC_PIN_IO     = 2'h0;
	localparam logic [1:0] DCC_PIN_ANALOG = 2'h1;
	localparam logic [1:0] DCC_PIN_DIG    = 2'h2;

	// Quarter phase counter width and value that marks the first quarter.
	localparam logic [1:0] DCC_Q1_PHASE = 2'h0;
endpackage

// File: hdl/dcc_mismatch.sv
// Mismatch detector for one comparator: sampling latch, reference latch and compare.
// Assumes the comparator level is already synchronised to CLK_SYS.
`timescale 1ns/1ns
module dcc_mismatch (
	input  wire logic clk,        // System clock.
	input  wire logic rst_b,      // Synchronised active-low reset.
	input  wire logic q1,         // First quarter phase strobe.
	input  wire logic ctrl_touch, // Read or write of the control register.
	input  wire logic level,      // Polarity-adjusted comparator level.
	output logic      mismatch,   // Sample differs from reference.
	output logic      rise        // Mismatch newly appears this cycle.
);
	logic sample_q;
	logic ref_q;
	logic mism_q;

	// Reference latch updates on control access; sample latch on first quarter.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_q <= 1'b0;
			ref_q    <= 1'b0;
			mism_q   <= 1'b0;
		end else begin
			if (ctrl_touch) begin
				ref_q <= level;
			end
			if (q1) begin
				sample_q <= level;
			end
			mism_q <= mismatch;
		end
	end

	// A control access forces the mismatch off in that cycle.
	assign mismatch = (sample_q ^ ref_q) & ~ctrl_touch;
	assign rise     = mismatch & ~mism_q;
endmodule

// File: testbench/dcc_analog_src.sv
// Analog sources on the comparator pins, held as millivolt levels per comparator.
// Assumes the block picks the inverting source with INV_SEL and powers cores with CMP_EN.
`timescale 1ns/1ns
module dcc_analog_src (
	input  wire logic [1:0] INV_SEL, // Inverting input select per comparator.
	input  wire logic [1:0] CMP_EN,  // Core enables.
	output logic      [1:0] CMP_RAW  // Raw comparison results, bit0 is comparator one.
);
	int vp[2];
	int vn[2];
	int va[2];
	// An enabled core goes high when its noninverting level is above the selected inverting level.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			CMP_RAW[i] = CMP_EN[i] && (vp[i] > (INV_SEL[i] ? va[i] : vn[i]));
		end
	end
	// Sets the noninverting, inverting and alternate inverting levels of one comparator.
	task automatic set_v(input int i, input int p, input int n, input int a);
		vp[i] <= p;
		vn[i] <= n;
		va[i] <= a;
	endtask
endmodule

// File: testbench/dcc_top_tb_top.sv
// Self-checking bench for the dual comparator control block, driven through its register port.
// Assumes the analog source model feeds the raw comparator results.
`timescale 1ns/1ns
module dcc_top_tb_top;
	import dcc_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst_b;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [1:0] cmp_raw;
	logic       cnt_clk;
	logic [5:0] pin_in;
	logic [5:0] port_out;
	logic [5:0] port_dir;
	logic [5:0] port_rd;
	logic [5:0] pin_out;
	logic [5:0] pin_oe_b;
	logic [5:0] pin_analog;
	logic [1:0] inv_sel;
	logic [1:0] cmp_en;
	logic       gate_out;
	logic       irq;
	int         n_errors = 0;
	int         n_tests = 0;
	int         cycles = 0;

	// Clock at 20 MHz.
	always #25 clk_sys = ~clk_sys;

	dcc_top i_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .CMP_RAW(cmp_raw), .CNT_CLK(cnt_clk), .PIN_IN(pin_in), .PORT_OUT(port_out),
		.PORT_DIR(port_dir), .PORT_RD(port_rd), .PIN_OUT(pin_out), .PIN_OE_B(pin_oe_b),
		.PIN_ANALOG(pin_analog), .INV_SEL(inv_sel), .CMP_EN(cmp_en), .GATE_OUT(gate_out), .IRQ(irq));

	dcc_analog_src i_src (.INV_SEL(inv_sel), .CMP_EN(cmp_en), .CMP_RAW(cmp_raw));

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize;
		$display("counts: tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Compares one value and reports a difference at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe.
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// One-cycle read strobe; the data are taken in the following cycle only.
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
		chk(d, exp);
	endtask

	// Lets the synchroniser, the quarter-phase sampler and the registered outputs catch up.
	task automatic settle;
		repeat (12) @(posedge clk_sys);
		#1;
	endtask

	// Cuts a hung run short.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end

	// Main sequence.
	initial begin
		rst_b = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		cnt_clk = 1'b1;
		pin_in = 6'h3f;
		port_out = 6'h00;
		port_dir = 6'h1b;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int a = 0; a < 4; a++) begin
			rd_chk(2'(a), 8'h00);
		end
		chk({2'h0, pin_analog & 6'h1b}, 8'h1b);
		$display("test reset done");

		// Interrupt enables stay off while the mode walks through all codes.
		i_src.set_v(0, 800, 200, 900);
		i_src.set_v(1, 800, 200, 900);
		for (int m = 0; m < 8; m++) begin
			wr_reg(DCC_ADDR_CTRL, 8'(m));
			settle();
			rd_chk(DCC_ADDR_CTRL, {((m == 0 || m == 7) ? 2'b00 : 2'b11), 6'(m)});
			chk({7'h0, cmp_en == 2'b00}, {7'h0, 1'(m == 0 || m == 7)});
			if (m == 0 || m == 4 || m == 7) chk({6'h0, d[7:6]}, (m == 4) ? 8'h03 : 8'h00);
			if (m == 0) chk({2'h0, port_rd & 6'h1b}, 8'h00);
			if (m == 7) chk({port_rd, pin_analog[1:0]}, 8'hfc);
			if (m == 4 || m == 6) chk({4'h0, pin_oe_b[5], pin_oe_b[2], pin_out[5], pin_out[2]}, (m == 6) ? 8'h03 : 8'h00);
		end
		$display("test modes done");

		i_src.set_v(1, 200, 800, 900);
		wr_reg(DCC_ADDR_CTRL, 8'h34);
		settle();
		rd_chk(DCC_ADDR_CTRL, 8'hb4);
		chk({7'h0, gate_out}, 8'h01);
		wr_reg(DCC_ADDR_CTRL, 8'h04);
		settle();
		rd_chk(DCC_ADDR_CTRL, 8'h44);
		chk({7'h0, gate_out}, 8'h00);
		$display("test polarity done");

		wr_reg(DCC_ADDR_CTRL, 8'h0a);
		settle();
		rd_chk(DCC_ADDR_CTRL, 8'h0a);
		chk({inv_sel, pin_analog}, 8'hdb);
		wr_reg(DCC_ADDR_CTRL, 8'h02);
		settle();
		rd_chk(DCC_ADDR_CTRL, 8'h42);
		wr_reg(DCC_ADDR_CTRL, 8'h09);
		settle();
		chk({6'h0, inv_sel}, 8'h01);
		$display("test input switch done");

		wr_reg(DCC_ADDR_CTRL, 8'h04);
		wr_reg(DCC_ADDR_CFG1, 8'h01);
		i_src.set_v(1, 800, 200, 900);
		settle();
		chk({7'h0, gate_out}, 8'h00);
		cnt_clk <= 1'b0;
		settle();
		chk({7'h0, gate_out}, 8'h01);
		wr_reg(DCC_ADDR_CFG1, 8'h00);
		$display("test gate sync done");

		rd_chk(DCC_ADDR_CTRL, 8'hc4);
		wr_reg(DCC_ADDR_FLAGS, 8'h00);
		rd_chk(DCC_ADDR_FLAGS, 8'h00);
		i_src.set_v(0, 200, 800, 900);
		settle();
		rd_chk(DCC_ADDR_FLAGS, 8'h08);
		chk({7'h0, irq}, 8'h00);
		wr_reg(DCC_ADDR_FLAGS, 8'h00);
		rd_chk(DCC_ADDR_FLAGS, 8'h08);
		rd_chk(DCC_ADDR_CTRL, 8'h84);
		wr_reg(DCC_ADDR_FLAGS, 8'h00);
		rd_chk(DCC_ADDR_FLAGS, 8'h00);
		i_src.set_v(0, 800, 200, 900);
		settle();
		rd_chk(DCC_ADDR_FLAGS, 8'h08);
		i_src.set_v(0, 200, 800, 900);
		settle();
		wr_reg(DCC_ADDR_FLAGS, 8'h00);
		rd_chk(DCC_ADDR_FLAGS, 8'h00);
		i_src.set_v(1, 200, 800, 900);
		settle();
		rd_chk(DCC_ADDR_FLAGS, 8'h10);
		wr_reg(DCC_ADDR_CTRL, 8'h04);
		wr_reg(DCC_ADDR_FLAGS, 8'h00);
		rd_chk(DCC_ADDR_FLAGS, 8'h00);
		$display("test change detect done");

		for (int i = 0; i < 8; i++) begin
			wr_reg(DCC_ADDR_MASK, i[0] ? 8'h08 : 8'h00);
			wr_reg(DCC_ADDR_CFG1, {i[2], i[1], 6'h00});
			wr_reg(DCC_ADDR_FLAGS, 8'h08);
			settle();
			chk({7'h0, irq}, {7'h0, 1'(i == 7)});
			rd_chk(DCC_ADDR_FLAGS, 8'h08);
			wr_reg(DCC_ADDR_FLAGS, 8'h00);
		end
		settle();
		chk({7'h0, irq}, 8'h00);
		$display("test irq enables done");
		summarize();
	end
endmodule
